// ===== rtl/vofc_params.svh
// offsets, field positions, reset values and limits for the
// output format block; assumes inclusion by vofc_pkg only
`ifndef VOFC_PARAMS_SVH
`define VOFC_PARAMS_SVH

// ---------------------------------------------------------
// register offsets and reset values
// ---------------------------------------------------------
`define ADDR_FMT    8'h01
`define ADDR_PIN    8'h02
`define ADDR_CTL    8'h04
`define ADDR_STAT   8'h10
`define RST_FMT     8'h00
`define RST_PIN     8'h00
`define RST_CTL     8'h00

// ---------------------------------------------------------
// field positions
// ---------------------------------------------------------
`define F_SIZE      2:0
`define F_CLIP      3
`define F_MODE      5:4
`define F_VSEL      6
`define F_KEEP      7
`define F_LPOL      0
`define F_FPOL      1
`define F_DPOL      2
`define F_CINV      3
`define F_SEN       4
`define F_VEN       5
`define F_FILL      7:6
`define F_RATE      4:3
`define F_LDEF      6

// ---------------------------------------------------------
// sample limits and fill colours
// ---------------------------------------------------------
`define NARROW_LO   8'h10
`define NARROW_YHI  8'heb
`define NARROW_CHI  8'hf0
`define WIDE_LO     8'h01
`define WIDE_HI     8'hfe
`define BLACK_Y     8'h10
`define BLACK_C     8'h80
`define BLUE_Y      8'h29
`define BLUE_CB     8'hf0
`define BLUE_CR     8'h6e

// ---------------------------------------------------------
// v bit line limits
// ---------------------------------------------------------
`define V525_END_A  10'd9
`define V525_END_B  10'd272
`define V525_WID_A  10'd19
`define V525_WID_B  10'd282
`define V525_F2     10'd264
`define V625_ON_A   10'd23
`define V625_OFF_A  10'd310
`define V625_ON_B   10'd336
`define V625_OFF_B  10'd623
`endif

// ===== rtl/vofc_pkg.sv
// types shared by the output format block and its bench;
// assumes the params header sits beside it
`include "vofc_params.svh"

package vofc_pkg;
   // picture size codes
   typedef enum logic [2:0] {
      SZ_QVGA = 3'h0, SZ_VGA = 3'h1, SZ_CIF = 3'h2,
      SZ_QCIF = 3'h3, SZ_RQVGA = 3'h4, SZ_RCIF = 3'h5,
      SZ_FULL = 3'h6, SZ_RSVD = 3'h7
   } size_t;
   // interface mode codes
   typedef enum logic [1:0] {
      IF_CAM = 2'h0, IF_CAM_TRS = 2'h1,
      IF_SYNC = 2'h2, IF_656 = 2'h3
   } mode_t;
   // one beat from the decoding core
   typedef struct packed {
      logic       is_trs;      // timing code slot
      logic [1:0] trs_idx;     // word within the code
      logic       trs_eav;     // end of line code
      logic [7:0] sample;      // luma or chroma code
      logic       is_chroma;
      logic       is_cr;
      logic       hsync;       // line sync active
      logic       vsync;       // frame sync active
      logic       field;       // second field
      logic       active;      // picture sample
      logic       frame_start; // first beat of frame
      logic [9:0] line;        // line number from 1
   } beat_t;
endpackage

// ===== rtl/video_output_format_control.sv
// output format control: size, clip, interface mode,
// timing codes, strobe polarity and no-signal fill.
// assumes a decoding core on I_CLK feeding beats and an
// upstream pixel clock on I_LINK_CLK, slower than I_CLK/4.
//
// Notes on behaviour
// - size field picks one of seven pictures
// - rotated sizes 240x180 and 288x216
// - clip bit clear limits samples 1..254
// - clip bit set limits 16..235/240
// - mode field picks camera, sync or 656
// - embedded modes hold syncs low unless enabled
// - v bit line select only at size 110
// - 525 lines, select clear: short v window
// - 525 lines, select set: long v window
// - 625 lines: fixed v window
// - skipped frames drop frame pulse unless kept in sync or 656 mode
// - polarity bits set strobe active levels
// - clock invert picks the receiver capture edge, not its time
// - line/frame strobes gated in embedded modes
// - valid strobe gated low on beats in embedded modes; idle link rises set it to its inactive level
// - no signal fills black, blue or raw
// - frame rate full, half or quarter
// - signal loss on both syncs or v only
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module video_output_format_control
   import vofc_pkg::*;
#(
   parameter int unsigned DEPTH = 2 // buffer entries
)(
   // clock, reset, enable
   input  wire logic       I_CLK,
   input  wire logic       I_RST_N,
   input  wire logic       I_CE,
   // register port
   input  wire logic [7:0] I_ADDR,
   input  wire logic [7:0] I_WDATA,
   input  wire logic       I_WR,
   input  wire logic       I_RD,
   output logic      [7:0] O_RDATA,
   // beats from the decoding core
   input  wire beat_t      I_BEAT,
   input  wire logic       I_BEAT_VALID,
   output logic            O_BEAT_READY,
   // core status
   input  wire logic       I_LINE_625,
   input  wire logic       I_HSYNC_LOST,
   input  wire logic       I_VSYNC_LOST,
   // upstream pixel clock
   input  wire logic       I_LINK_CLK,
   // video pins
   output logic      [7:0] O_DATA,
   output logic            O_LINE_SYNC,
   output logic            O_FRAME_SYNC,
   output logic            O_DATA_VALID,
   output logic            O_PIXEL_CLOCK,
   output logic            O_SIGNAL_LOSS,
   output logic            O_VBIT,
   output logic      [9:0] O_PIC_WIDTH,
   output logic      [9:0] O_PIC_HEIGHT
);

   // ---------------------------------------------------------
   // state
   // ---------------------------------------------------------
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

   typedef struct packed {
      logic [7:0]        fmt_reg;  // format config
      logic [7:0]        pin_reg;  // pin config
      logic [7:0]        ctl_reg;  // rate and loss config
      logic [7:0]        fmt_act;  // format in use
      logic [7:0]        pin_act;  // pins in use
      logic [7:0]        ctl_act;  // rate in use
      logic [7:0]        rdata;    // read answer
      logic [2:0]        sync;     // link clock sampler
      logic              lclk;     // settled link clock
      beat_t [DEPTH-1:0] mem;      // beat buffer
      logic [PW-1:0]     wp;
      logic [PW-1:0]     rp;
      logic [PW:0]       cnt;
      logic [1:0]        fcnt;     // frame counter
      logic              fon;      // frame not skipped
      logic [7:0]        data;
      logic              lsync;
      logic              fsync;
      logic              dval;
      logic              pclk;
      logic              loss;
      logic              vbit;
      logic [9:0]        wid;
      logic [9:0]        hgt;
   } st_t;

   st_t r_reg;   // registered state
   st_t r_next;  // next state

   // ---------------------------------------------------------
   // helpers
   // ---------------------------------------------------------
   // v bit of the timing code for a given line
   function automatic logic vbit_f(input logic [9:0] ln,
                                   input logic l625,
                                   input logic wide);
      logic [9:0] e1;
      logic [9:0] e2;
      e1 = wide ? `V525_WID_A : `V525_END_A;
      e2 = wide ? `V525_WID_B : `V525_END_B;
      if (l625) begin
         vbit_f = !((ln >= `V625_ON_A && ln <= `V625_OFF_A) ||
                    (ln >= `V625_ON_B && ln <= `V625_OFF_B));
      end else begin
         vbit_f = (ln >= 10'd1 && ln <= e1) ||
                  (ln >= `V525_F2 && ln <= e2);
      end
   endfunction

   // clamp one sample to the selected code range
   function automatic logic [7:0] clip_f(input logic [7:0] s,
                                         input logic nar,
                                         input logic chroma);
      logic [7:0] lo;
      logic [7:0] hi;
      lo = nar ? `NARROW_LO : `WIDE_LO;
      hi = !nar ? `WIDE_HI :
           (chroma ? `NARROW_CHI : `NARROW_YHI);
      if (s < lo) begin
         clip_f = lo;
      end else if (s > hi) begin
         clip_f = hi;
      end else begin
         clip_f = s;
      end
   endfunction

   // timing code word, protection bits from f, v, h
   function automatic logic [7:0] trs_f(input logic [1:0] idx,
                                        input logic f,
                                        input logic v,
                                        input logic h);
      unique case (idx)
         2'd0: trs_f = 8'hff;
         2'd1: trs_f = 8'h00;
         2'd2: trs_f = 8'h00;
         2'd3: trs_f = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v,
                        f ^ v ^ h};
      endcase
   endfunction

   // ---------------------------------------------------------
   // next state
   // ---------------------------------------------------------
   // all behaviour in one pass over a copy of the state
   always_comb begin
      logic       settled;   // sampler second and third agree
      logic       rise;      // settled link clock rising
      logic       push;
      logic       pop;
      beat_t      b;
      logic [7:0] fmt;
      logic [7:0] pin;
      logic [7:0] ctl;
      logic       emb;       // embedded code mode
      logic       strobe_m;  // sync or 656 mode
      logic [1:0] cnt_n;
      logic       on;
      logic       vwide;
      logic [7:0] s;
      logic       ls_a;
      logic       fs_a;
      logic       dv_a;
      settled  = 1'b0;
      rise     = 1'b0;
      push     = 1'b0;
      pop      = 1'b0;
      b        = '0;
      fmt      = r_reg.fmt_act;
      pin      = r_reg.pin_act;
      ctl      = r_reg.ctl_act;
      emb      = 1'b0;
      strobe_m = 1'b0;
      cnt_n    = r_reg.fcnt;
      on       = r_reg.fon;
      vwide    = 1'b0;
      s        = 8'h00;
      ls_a     = 1'b0;
      fs_a     = 1'b0;
      dv_a     = 1'b0;
      r_next   = r_reg;

      // register writes, reads answer the next cycle only
      r_next.rdata = 8'h00;
      if (I_WR) begin
         unique case (I_ADDR)
            `ADDR_FMT: r_next.fmt_reg = I_WDATA;
            `ADDR_PIN: r_next.pin_reg = I_WDATA;
            `ADDR_CTL: r_next.ctl_reg = I_WDATA;
            default:   r_next.rdata   = 8'h00;
         endcase
      end
      if (I_RD) begin
         unique case (I_ADDR)
            `ADDR_FMT:  r_next.rdata = r_reg.fmt_reg;
            `ADDR_PIN:  r_next.rdata = r_reg.pin_reg;
            `ADDR_CTL:  r_next.rdata = r_reg.ctl_reg;
            `ADDR_STAT: r_next.rdata = {5'h00, r_reg.vbit,
                                        r_reg.fon, r_reg.loss};
            default:    r_next.rdata = 8'h00; // unmapped
         endcase
      end

      // link clock sampler; a level counts once it settles
      r_next.sync = {r_reg.sync[1:0], I_LINK_CLK};
      settled = (r_reg.sync[1] == r_reg.sync[2]);
      if (settled) begin
         r_next.lclk = r_reg.sync[2];
      end
      rise = settled && r_reg.sync[2] && !r_reg.lclk;

      // two-entry buffer; drained only on link edges so a
      // slow pixel clock back-pressures the core
      push = I_BEAT_VALID && (r_reg.cnt != FULL);
      pop  = rise && (r_reg.cnt != '0);
      if (push) begin
         r_next.mem[r_reg.wp] = I_BEAT;
         r_next.wp = (r_reg.wp == PW'(DEPTH - 1)) ?
                     '0 : r_reg.wp + 1'b1;
      end
      if (pop) begin
         r_next.rp = (r_reg.rp == PW'(DEPTH - 1)) ?
                     '0 : r_reg.rp + 1'b1;
      end
      if (push && !pop) begin
         r_next.cnt = r_reg.cnt + 1'b1;
      end else if (pop && !push) begin
         r_next.cnt = r_reg.cnt - 1'b1;
      end

      // loss of signal follows the live definition bit
      r_next.loss = I_VSYNC_LOST &&
                    (r_reg.ctl_reg[`F_LDEF] || I_HSYNC_LOST);

      // idle link edge: nothing valid to show
      if (rise && !pop) begin
         r_next.dval = !pin[`F_DPOL];
      end

      if (pop) begin
         b = r_reg.mem[r_reg.rp];
         // new settings only at a frame's first beat
         if (b.frame_start) begin
            fmt = r_reg.fmt_reg;
            pin = r_reg.pin_reg;
            ctl = r_reg.ctl_reg;
            r_next.fmt_act = fmt;
            r_next.pin_act = pin;
            r_next.ctl_act = ctl;
            cnt_n = r_reg.fcnt + 2'd1;
            // reserved rate code runs at full rate
            unique case (ctl[`F_RATE])
               2'b01:   on = !cnt_n[0];
               2'b10:   on = (cnt_n == 2'd0);
               default: on = 1'b1;
            endcase
            r_next.fcnt = cnt_n;
            r_next.fon  = on;
         end
         emb      = fmt[4];
         strobe_m = fmt[5];
         vwide    = fmt[`F_VSEL] &&
                    (size_t'(fmt[`F_SIZE]) == SZ_FULL);
         r_next.vbit = vbit_f(b.line, I_LINE_625, vwide);

         // sample path: fill on loss, then clip
         s = b.sample;
         if (r_reg.loss) begin
            unique case (pin[`F_FILL])
               2'b00: s = b.is_chroma ? `BLACK_C : `BLACK_Y;
               2'b01: s = !b.is_chroma ? `BLUE_Y :
                          (b.is_cr ? `BLUE_CR : `BLUE_CB);
               default: s = b.sample;
            endcase
         end
         s = clip_f(s, fmt[`F_CLIP], b.is_chroma);

         // timing codes appear only in embedded modes
         if (b.is_trs) begin
            if (emb) begin
               r_next.data = trs_f(b.trs_idx, b.field,
                                   r_next.vbit, b.trs_eav);
            end
         end else begin
            r_next.data = s;
         end

         // strobe activity before gating and polarity
         ls_a = b.hsync;
         fs_a = b.vsync && (on ||
                (strobe_m && fmt[`F_KEEP]));
         dv_a = b.active && !b.is_trs && on;
         if (emb && !pin[`F_SEN]) begin
            r_next.lsync = 1'b0;
            r_next.fsync = 1'b0;
         end else begin
            r_next.lsync = !(ls_a ^ pin[`F_LPOL]);
            r_next.fsync = !(fs_a ^ pin[`F_FPOL]);
         end
         if (emb && !pin[`F_VEN]) begin
            r_next.dval = 1'b0;
         end else begin
            r_next.dval = !(dv_a ^ pin[`F_DPOL]);
         end
      end

      // data moves at link rise; the receiver's edge falls
      // half a link period later, whichever phase it uses
      r_next.pclk = r_next.lclk ^ !r_next.pin_act[`F_CINV];

      // picture size from the format in use
      unique case (size_t'(r_reg.fmt_act[`F_SIZE]))
         SZ_QVGA:  {r_next.wid, r_next.hgt} = {10'd320, 10'd240};
         SZ_VGA:   {r_next.wid, r_next.hgt} = {10'd640, 10'd480};
         SZ_CIF:   {r_next.wid, r_next.hgt} = {10'd352, 10'd288};
         SZ_QCIF:  {r_next.wid, r_next.hgt} = {10'd176, 10'd144};
         SZ_RQVGA: {r_next.wid, r_next.hgt} = {10'd240, 10'd180};
         SZ_RCIF:  {r_next.wid, r_next.hgt} = {10'd288, 10'd216};
         SZ_FULL:  {r_next.wid, r_next.hgt} =
                      {10'd720, I_LINE_625 ? 10'd576 : 10'd480};
         SZ_RSVD:  {r_next.wid, r_next.hgt} = {10'd0, 10'd0};
      endcase
   end

   // ---------------------------------------------------------
   // state register
   // ---------------------------------------------------------
   // everything clears to zero: all configs reset to 00
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         r_reg <= '0;
      end else if (I_CE) begin
         r_reg <= r_next;
      end
   end

   // ---------------------------------------------------------
   // outputs
   // ---------------------------------------------------------
   assign O_RDATA       = r_reg.rdata;
   assign O_BEAT_READY  = (r_reg.cnt != FULL) && I_CE;
   assign O_DATA        = r_reg.data;
   assign O_LINE_SYNC   = r_reg.lsync;
   assign O_FRAME_SYNC  = r_reg.fsync;
   assign O_DATA_VALID  = r_reg.dval;
   assign O_PIXEL_CLOCK = r_reg.pclk;
   assign O_SIGNAL_LOSS = r_reg.loss;
   assign O_VBIT        = r_reg.vbit;
   assign O_PIC_WIDTH   = r_reg.wid;
   assign O_PIC_HEIGHT  = r_reg.hgt;

endmodule

`default_nettype wire

// ===== dv/vofc_asserts.sv
// checker for the output format block, bound to its top
// assumes a link clock of about eight system cycles
`timescale 1ns/1ps
`default_nettype none

module vofc_asserts (
   // clock and reset
   input wire logic       I_CLK,
   input wire logic       I_RST_N,
   input wire logic       I_CE,
   // register port
   input wire logic [7:0] I_ADDR,
   input wire logic       I_RD,
   input wire logic [7:0] O_RDATA,
   // beat handshake
   input wire logic       I_BEAT_VALID,
   input wire logic       O_BEAT_READY,
   // status and link
   input wire logic       I_HSYNC_LOST,
   input wire logic       I_VSYNC_LOST,
   input wire logic       I_LINK_CLK,
   // video pins
   input wire logic [7:0] O_DATA,
   input wire logic       O_LINE_SYNC,
   input wire logic       O_FRAME_SYNC,
   input wire logic       O_DATA_VALID,
   input wire logic       O_PIXEL_CLOCK,
   input wire logic       O_SIGNAL_LOSS,
   input wire logic       O_VBIT
);
   // ----------
   // age of the last link rise
   // ----------
   logic       link_q;    // link level one edge ago
   logic [4:0] since_reg; // saturating cycles since rise
   logic       in_slot;   // where rise-driven updates land

   // raw sampling is coarser than the synchroniser,
   // so the slot is a window rather than one cycle
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         link_q    <= 1'b0;
         since_reg <= 5'h00;
      end else begin
         link_q <= I_LINK_CLK;
         if (I_LINK_CLK && !link_q) begin
            since_reg <= 5'h00;
         end else if (since_reg != 5'h1f) begin
            since_reg <= since_reg + 5'h01;
         end
      end
   end
   assign in_slot = (since_reg >= 5'h02) && (since_reg <= 5'h05);

   // ----------
   // properties
   // ----------
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (!I_RST_N);

   rdata_idle_a: assert property (I_CE && !I_RD |=> O_RDATA == 8'h00)
      else $error("read data without a read");
   unmapped_read_a: assert property (I_CE && I_RD &&
      !(I_ADDR inside {8'h01, 8'h02, 8'h04, 8'h10}) |=> O_RDATA == 8'h00)
      else $error("unmapped read not zero");
   ready_ce_a: assert property (!I_CE |-> !O_BEAT_READY)
      else $error("ready while frozen");
   ready_fall_a: assert property ($fell(O_BEAT_READY) && I_CE &&
      $past(I_CE) |-> $past(I_BEAT_VALID))
      else $error("ready fell with no beat taken");
   loss_both_a: assert property (
      I_CE && I_HSYNC_LOST && I_VSYNC_LOST |=> O_SIGNAL_LOSS)
      else $error("both syncs lost but no loss flag");
   loss_needs_v_a: assert property (
      I_CE && !I_VSYNC_LOST |=> !O_SIGNAL_LOSS)
      else $error("loss flag with frame sync present");
   data_slot_a: assert property ($changed(O_DATA) |-> in_slot)
      else $error("data moved away from a link rise");
   strobe_slot_a: assert property (
      $changed(O_LINE_SYNC) || $changed(O_FRAME_SYNC) ||
      $changed(O_DATA_VALID) |-> in_slot)
      else $error("strobe moved away from a link rise");
   vbit_slot_a: assert property ($changed(O_VBIT) |-> in_slot)
      else $error("v bit moved away from a link rise");

   // main scenarios reached
   cover property ($fell(O_BEAT_READY));
   cover property ($rose(O_SIGNAL_LOSS));
   cover property ($rose(O_PIXEL_CLOCK));
endmodule

bind video_output_format_control vofc_asserts u_vofc_asserts (
   .I_CLK, .I_RST_N, .I_CE, .I_ADDR, .I_RD, .O_RDATA, .I_BEAT_VALID,
   .O_BEAT_READY, .I_HSYNC_LOST, .I_VSYNC_LOST, .I_LINK_CLK, .O_DATA,
   .O_LINE_SYNC, .O_FRAME_SYNC, .O_DATA_VALID, .O_PIXEL_CLOCK,
   .O_SIGNAL_LOSS, .O_VBIT);
`default_nettype wire

// ===== dv/capture_port_model.sv
// host capture port: latches the video byte on the agreed edge
// assumes i_inv follows the invert bit the block is using
`timescale 1ns/1ps
`default_nettype none

module capture_port_model (
   // pins from the block
   input  wire logic       i_pclk,
   input  wire logic [7:0] i_data,
   input  wire logic       i_inv,
   // last word and running count
   output var  logic [7:0] o_word,
   output var  int         o_count
);
   initial o_count = 0;
   // rising edge normally, falling edge when inverted
   always @(i_pclk) begin
      if (i_pclk != i_inv) begin
         o_word  <= i_data;
         o_count <= o_count + 1;
      end
   end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the output format block
// assumes the checker and the capture model compile first
`timescale 1ns/1ps
`default_nettype none

module tb_top
   import vofc_pkg::*;
;
   // ----------
   // signals
   // ----------
   logic       clk, rst_n, ce, wr, rd, bval, lclk;
   logic       l625, hl, vl, inv;
   logic [7:0] addr, wdata, rdata, data, cap;
   beat_t      beat;
   logic       ready, ls, fs, dv, pclk, loss, vbit;
   logic [9:0] pw, ph;
   int         n_fail = 0, n_checks = 0, n_cap, cyc = 0;

   video_output_format_control u_video_output_format_control (
      .I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_ADDR(addr),
      .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
      .I_BEAT(beat), .I_BEAT_VALID(bval), .O_BEAT_READY(ready),
      .I_LINE_625(l625), .I_HSYNC_LOST(hl), .I_VSYNC_LOST(vl),
      .I_LINK_CLK(lclk), .O_DATA(data), .O_LINE_SYNC(ls),
      .O_FRAME_SYNC(fs), .O_DATA_VALID(dv), .O_PIXEL_CLOCK(pclk),
      .O_SIGNAL_LOSS(loss), .O_VBIT(vbit), .O_PIC_WIDTH(pw),
      .O_PIC_HEIGHT(ph));
   capture_port_model u_capture_port_model (.i_pclk(pclk),
      .i_data(data), .i_inv(inv), .o_word(cap), .o_count(n_cap));

   // ----------
   // clocks and hang guard
   // ----------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // link edges kept 13 ns ahead of a system clock rise
   initial begin
      lclk = 1'b0;
      #7;
      forever #160 lclk = ~lclk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end

   // ----------
   // shared tasks
   // ----------
   task automatic chk(input string n, input logic [9:0] e,
                      input logic [9:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk("register", 10'(e), 10'(rdata));
   endtask
   function automatic beat_t mk(input logic [7:0] s, input logic c,
                                input logic [9:0] ln, input logic h);
      beat_t b;
      b             = '0;
      b.sample      = s;
      b.is_chroma   = c;
      b.line        = ln;
      b.hsync       = h;
      b.vsync       = h;
      b.active      = 1'b1;
      b.frame_start = 1'b1;
      return b;
   endfunction
   // first copy loads settings; second is judged after its pop
   // and capture, before an idle rise can clear data valid
   task automatic send(input beat_t b);
      repeat (2) begin
         @(posedge clk);
         beat <= b;
         bval <= 1'b1;
         @(negedge clk);
         while (ready !== 1'b1) @(negedge clk);
         @(posedge clk);
         bval <= 1'b0;
         @(negedge clk);
         while (pclk !== !inv) @(negedge clk);
         while (pclk !== inv) @(negedge clk);
         while (pclk !== !inv) @(negedge clk);
      end
   endtask
   task automatic lost(input logic h, input logic v, input logic e);
      @(posedge clk);
      hl <= h;
      vl <= v;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("signal loss", 10'(e), 10'(loss));
   endtask

   // ----------
   // scenarios
   // ----------
   task automatic t_regs();
      rd_reg(8'h01, 8'h00);
      rd_reg(8'h02, 8'h00);
      rd_reg(8'h04, 8'h00);
      wr_reg(8'h02, 8'ha5);
      rd_reg(8'h02, 8'ha5);
      wr_reg(8'h04, 8'h58);
      rd_reg(8'h04, 8'h58);
      rd_reg(8'h33, 8'h00);
      wr_reg(8'h02, 8'h00);
      wr_reg(8'h04, 8'h00);
   endtask
   task automatic t_sizes();
      logic [9:0] w[8];
      logic [9:0] h[8];
      w = '{10'h140, 10'h280, 10'h160, 10'h0b0,
            10'h0f0, 10'h120, 10'h2d0, 10'h000};
      h = '{10'h0f0, 10'h1e0, 10'h120, 10'h090,
            10'h0b4, 10'h0d8, 10'h1e0, 10'h000};
      for (int i = 0; i < 8; i++) begin
         wr_reg(8'h01, {5'h00, i[2:0]});
         send(mk(8'h80, 1'b0, 10'h00a, 1'b0));
         chk("picture width", w[i], pw);
         chk("picture height", h[i], ph);
      end
   endtask
   // {clip, chroma, input, expected}
   task automatic t_clip();
      logic [23:0] t[6];
      t = '{24'h000001, 24'h01fffe, 24'h100510,
            24'h10f0eb, 24'h11f8f0, 24'h110310};
      for (int i = 0; i < 6; i++) begin
         wr_reg(8'h01, {4'h0, t[i][20], 3'h0});
         send(mk(t[i][15:8], t[i][16], 10'h00a, 1'b0));
         chk("clipped sample", 10'(t[i][7:0]), 10'(cap));
      end
   endtask
   // {625 lines, select, expected v, line}
   task automatic t_vbit();
      logic [27:0] v[13];
      v = '{28'h0010009, 28'h000000a, 28'h0010110, 28'h0000111,
            28'h0110013, 28'h0100014, 28'h011011a, 28'h010011b,
            28'h1110016, 28'h1100017, 28'h1100136, 28'h1110137,
            28'h1100150};
      for (int i = 0; i < 13; i++) begin
         l625 <= v[i][24];
         wr_reg(8'h01, {1'b0, v[i][20], 6'h36});
         send(mk(8'h80, 1'b0, v[i][9:0], 1'b0));
         chk("v bit", 10'(v[i][16]), 10'(vbit));
      end
      l625 <= 1'b0;
      wr_reg(8'h01, 8'h70);
      send(mk(8'h80, 1'b0, 10'h00f, 1'b0));
      chk("v bit other size", 10'h000, 10'(vbit));
   endtask
   // {format, pins, sync in, sync out, valid out}
   task automatic t_strobe();
      logic [27:0] s[7];
      s = '{28'h2000100, 28'h2007111, 28'h2007001, 28'h1007100,
            28'h1037111, 28'h3000000, 28'h0004011};
      for (int i = 0; i < 7; i++) begin
         wr_reg(8'h01, s[i][27:20]);
         wr_reg(8'h02, s[i][19:12]);
         send(mk(8'h80, 1'b0, 10'h00a, s[i][8]));
         chk("line sync", 10'(s[i][4]), 10'(ls));
         chk("frame sync", 10'(s[i][4]), 10'(fs));
         chk("data valid", 10'(s[i][0]), 10'(dv));
      end
   endtask
   task automatic t_loss();
      logic [7:0] f[3];
      f = '{8'h10, 8'h29, 8'h77};
      lost(1'b1, 1'b0, 1'b0);
      lost(1'b1, 1'b1, 1'b1);
      lost(1'b0, 1'b1, 1'b0);
      wr_reg(8'h04, 8'h40);
      lost(1'b0, 1'b1, 1'b1);
      wr_reg(8'h01, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr_reg(8'h02, {i[1:0], 6'h00});
         send(mk(8'h77, 1'b0, 10'h00a, 1'b0));
         chk("no signal fill", 10'(f[i]), 10'(cap));
      end
      wr_reg(8'h02, 8'h00);
      wr_reg(8'h04, 8'h00);
      lost(1'b0, 1'b0, 1'b0);
   endtask
   // just after link fall the output clock still shows the invert setting
   task automatic t_inv();
      for (int i = 1; i >= 0; i--) begin
         wr_reg(8'h02, {4'h0, i[0], 3'h0});
         inv <= i[0];
         send(mk(8'h5a, 1'b0, 10'h00a, 1'b0));
         chk("captured word", 10'h05a, 10'(cap));
         @(posedge lclk);
         #250;
         chk("pixel clock", 10'(i[0]), 10'(pclk));
      end
   endtask
   // hold a beat up until the two-entry buffer refuses
   task automatic t_buffer();
      int n0;
      @(posedge clk);
      beat <= mk(8'h41, 1'b0, 10'h00a, 1'b0);
      bval <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("ready when full", 10'h000, 10'(ready));
      @(posedge clk);
      bval <= 1'b0;
      n0 = n_cap;
      while (n_cap < n0 + 6) @(posedge clk);
      chk("drained word", 10'h041, 10'(cap));
      ce <= 1'b0;
      @(negedge clk);
      chk("ready frozen", 10'h000, 10'(ready));
      @(posedge clk);
      ce <= 1'b1;
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ----------
   // main sequence
   // ----------
   initial begin
      rst_n = 1'b0;
      ce    = 1'b1;
      beat  = '0;
      {wr, rd, bval, l625, hl, vl, inv, addr, wdata} = 23'h000000;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_sizes();
      t_clip();
      t_vbit();
      t_strobe();
      t_loss();
      t_inv();
      t_buffer();
      results();
   end
endmodule
`default_nettype wire
